// File: core/ssc_pkg.sv
package ssc_pkg;
   localparam int DATA_W = 32;
   localparam int PAR_W = 4;
   localparam int LANES = 4;
   localparam int BYTE_W = 8;
   localparam int LANE_W = BYTE_W + 1;
   localparam int WORD_W = LANES * LANE_W;
   localparam int ADDR_W = 18;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = ADDR_W + LANES + WORD_W;
   localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h0_0000;
   localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;

   typedef enum logic [1:0] {
      SSC_IDLE,
      SSC_READ,
      SSC_WRITE
   } ssc_op_t;
endpackage

// File: core/ssc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   // Sized one bit wider than the pointers so a full queue is not zero
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW:0] CNT_ZERO = '0;
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [PW-1:0] PTR_ZERO = '0;

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
      ptr_next = (p == PTR_LAST) ? PTR_ZERO : p + PW'(1);
   endfunction

   assign in_ready = (count_q != CNT_FULL);
   assign out_valid = (count_q != CNT_ZERO);
   assign out_data = mem[rd_ptr_q];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= PTR_ZERO;
         rd_ptr_q <= PTR_ZERO;
         count_q <= CNT_ZERO;
      end else begin
         if (push) wr_ptr_q <= ptr_next(wr_ptr_q);
         if (pop) rd_ptr_q <= ptr_next(rd_ptr_q);
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// File: core/ssc_sram.sv
// How it works
// RULE_01: Second select joins selection at clock edge
// RULE_02: Output enable low lets read data drive
// RULE_03: Output enable high floats pins, input mode
// RULE_04: Outputs off during write data phase
// RULE_05: Outputs off first clock after deselect
// RULE_06: Outputs off while deselected
// RULE_07: Act on edge only when qualify low
// RULE_08: Qualify high masks every register update
// RULE_09: Stall stretches cycle, never deselects
// RULE_10: Input data captured into data register
// RULE_11: Read drives word of previous address
// RULE_12: Parity like data, written per lane select
// RULE_13: One enable gates all pipeline registers
`timescale 1ns/100ps
`default_nettype none
module ssc_sram
   import ssc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic chip_select_one_n,
   input wire logic chip_select_two,
   input wire logic chip_select_three_n,
   input wire logic clock_qualify_n,
   input wire logic write_enable_n,
   input wire logic out_enable_n,
   input wire logic [LANES-1:0] byte_write_select_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   input wire logic [PAR_W-1:0] parity_io_lines_in,
   output logic [PAR_W-1:0] parity_io_lines_out,
   output logic parity_oe_n,
   output logic write_ready
);
   logic [WORD_W-1:0] array_q [2**ADDR_W];

   ssc_op_t s1_op_q;
   ssc_op_t s2_op_q;
   logic [ADDR_W-1:0] s1_addr_q;
   logic [ADDR_W-1:0] s2_addr_q;
   logic [LANES-1:0] s1_bw_n_q;
   logic [LANES-1:0] s2_bw_n_q;
   logic [WORD_W-1:0] dout_q;
   logic [WORD_W-1:0] din_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [LANES-1:0] wr_bw_n_q;
   logic wr_pend_q;
   logic emerge_q;

   // Qualified clock: every register below moves only on this
   wire qualify = !clock_qualify_n; // RULE_07
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [FIFO_W-1:0] fifo_out_data;
   // A pending write that finds the queue full holds the pipe like a stall
   wire advance = qualify && !(wr_pend_q && !fifo_in_ready); // RULE_13
   wire selected = !chip_select_one_n && chip_select_two
      && !chip_select_three_n; // RULE_01
   ssc_op_t s1_op_d;
   assign s1_op_d = !selected ? SSC_IDLE :
      (!write_enable_n ? SSC_WRITE : SSC_READ);

   // Array has one port: a read in stage one blocks draining
   wire drain = qualify && fifo_out_valid && (s1_op_q != SSC_READ);
   wire [ADDR_W-1:0] drain_addr = fifo_out_data[FIFO_W-1 -: ADDR_W];
   wire [LANES-1:0] drain_bw_n = fifo_out_data[WORD_W +: LANES];
   wire [WORD_W-1:0] drain_word = fifo_out_data[WORD_W-1:0];
   wire [WORD_W-1:0] rd_word = array_q[s1_addr_q];

   // Lane layout: byte k in bits 9k..9k+7, its parity at 9k+8
   function automatic logic [WORD_W-1:0] pack_word(
      input logic [DATA_W-1:0] d, input logic [PAR_W-1:0] p);
      logic [WORD_W-1:0] w;
      w = WORD_RESET;
      for (int k = 0; k < LANES; k++) begin
         w[k*LANE_W +: LANE_W] = {p[k], d[k*BYTE_W +: BYTE_W]};
      end
      return w;
   endfunction

   function automatic logic [WORD_W-1:0] merge_lanes(
      input logic [WORD_W-1:0] old, input logic [WORD_W-1:0] nw,
      input logic [LANES-1:0] bw_n);
      logic [WORD_W-1:0] w;
      w = old;
      for (int k = 0; k < LANES; k++) begin
         if (!bw_n[k]) w[k*LANE_W +: LANE_W] = nw[k*LANE_W +: LANE_W];
      end
      return w;
   endfunction

   always_ff @(posedge mclk) begin
      if (drain) begin
         array_q[drain_addr] <= merge_lanes(array_q[drain_addr],
            drain_word, drain_bw_n); // RULE_12
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_op_q <= SSC_IDLE;
         s2_op_q <= SSC_IDLE;
         s1_addr_q <= ADDR_RESET;
         s2_addr_q <= ADDR_RESET;
         s1_bw_n_q <= LANES_OFF_N;
         s2_bw_n_q <= LANES_OFF_N;
         emerge_q <= 1'b0;
      end else if (advance) begin // RULE_08 RULE_09
         s1_op_q <= s1_op_d;
         s1_addr_q <= addr;
         s1_bw_n_q <= byte_write_select_n;
         s2_op_q <= s1_op_q;
         s2_addr_q <= s1_addr_q;
         s2_bw_n_q <= s1_bw_n_q;
         emerge_q <= (s1_op_q != SSC_IDLE) && (s2_op_q == SSC_IDLE);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dout_q <= WORD_RESET;
      end else if (advance && s1_op_q == SSC_READ) begin
         dout_q <= rd_word; // RULE_11
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         din_q <= WORD_RESET;
         wr_addr_q <= ADDR_RESET;
         wr_bw_n_q <= LANES_OFF_N;
         wr_pend_q <= 1'b0;
      end else if (advance) begin
         wr_pend_q <= (s2_op_q == SSC_WRITE);
         if (s2_op_q == SSC_WRITE) begin
            din_q <= pack_word(dq_in, parity_io_lines_in); // RULE_10 RULE_12
            wr_addr_q <= s2_addr_q;
            wr_bw_n_q <= s2_bw_n_q;
         end
      end
   end

   // Write data pushes only on a qualified edge
   ssc_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wq (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(wr_pend_q && qualify),
      .in_ready(fifo_in_ready),
      .in_data({wr_addr_q, wr_bw_n_q, din_q}),
      .out_valid(fifo_out_valid),
      .out_ready(drain),
      .out_data(fifo_out_data)
   );

   // Output enable pin acts without the clock; the rest is registered
   wire drive = !out_enable_n // RULE_02 RULE_03
      && (s2_op_q == SSC_READ) // RULE_04 RULE_06
      && !emerge_q; // RULE_05
   assign dq_oe_n = !drive;
   assign parity_oe_n = !drive; // RULE_12
   assign write_ready = fifo_in_ready;

   always_comb begin
      for (int k = 0; k < LANES; k++) begin
         dq_out[k*BYTE_W +: BYTE_W] = dout_q[k*LANE_W +: BYTE_W];
         parity_io_lines_out[k] = dout_q[k*LANE_W + BYTE_W];
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sel_needs_two_a: assert property ( // RULE_01
      advance && !chip_select_two |=> s1_op_q == SSC_IDLE)
      else $error("Stage one selected with second select low");
   read_drive_a: assert property ( // RULE_02
      s2_op_q == SSC_READ && !out_enable_n && !emerge_q |-> !dq_oe_n)
      else $error("Read with output enable low does not drive");
   oe_high_off_a: assert property ( // RULE_03
      out_enable_n |-> dq_oe_n && parity_oe_n)
      else $error("Pins driven while output enable high");
   write_phase_off_a: assert property ( // RULE_04
      s2_op_q == SSC_WRITE |-> dq_oe_n)
      else $error("Pins driven in write data phase");
   emerge_off_a: assert property ( // RULE_05
      advance && s1_op_q != SSC_IDLE && s2_op_q == SSC_IDLE |=> dq_oe_n)
      else $error("Pins driven on first clock after deselect");
   desel_off_a: assert property ( // RULE_06
      advance && s1_op_q == SSC_IDLE |=> dq_oe_n)
      else $error("Pins driven while deselected");
   stall_hold_a: assert property ( // RULE_08
      clock_qualify_n |=> $stable(dout_q) && $stable(s2_op_q)
         && $stable(s1_op_q) && $stable(din_q))
      else $error("State changed on a masked edge");
   stall_no_desel_a: assert property ( // RULE_09
      clock_qualify_n ##1 clock_qualify_n |-> $stable(s1_op_q))
      else $error("Stall treated as deselect");
   capture_data_a: assert property ( // RULE_10
      advance && s2_op_q == SSC_WRITE
         |=> din_q == pack_word($past(dq_in), $past(parity_io_lines_in)))
      else $error("Input data not captured");
   read_word_a: assert property ( // RULE_11
      advance && s1_op_q == SSC_READ |=> dout_q == $past(rd_word))
      else $error("Read data not from sampled address");
   lane_guard_a: assert property ( // RULE_12
      drain && drain_bw_n[0] |=> array_q[$past(drain_addr)][LANE_W-1:0]
         == $past(array_q[drain_addr][LANE_W-1:0]))
      else $error("Unselected lane written");
   enable_all_a: assert property ( // RULE_13
      !qualify |=> $stable(fifo_out_valid) && $stable(fifo_in_ready)
         && $stable(wr_pend_q) && $stable(emerge_q))
      else $error("Queue moved on a masked edge");

   read_seen_c: cover property (advance && s1_op_q == SSC_READ ##1 !dq_oe_n);
   write_seen_c: cover property (drain);
   stall_seen_c: cover property (clock_qualify_n [*3] ##1 qualify);
   full_seen_c: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

// File: tb/ssc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model
   import ssc_pkg::*;
(
   input wire logic mclk,
   input wire logic h_en,
   input wire logic [DATA_W-1:0] hd,
   input wire logic [PAR_W-1:0] hp,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic [PAR_W-1:0] par_out,
   input wire logic par_oe_n,
   output logic [DATA_W-1:0] dq_line,
   output logic [PAR_W-1:0] par_line
);
   logic [DATA_W-1:0] last_d_q = '0;
   logic [PAR_W-1:0] last_p_q = '0;
   // Released lines flip so stale data never passes as read data
   assign dq_line = !dq_oe_n ? dq_out : h_en ? hd : ~last_d_q;
   assign par_line = !par_oe_n ? par_out : h_en ? hp : ~last_p_q;
   always @(posedge mclk) begin
      last_d_q <= dq_line;
      last_p_q <= par_line;
   end
endmodule
`default_nettype wire

// File: tb/ssc_sram_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_sram_tb_top
   import ssc_pkg::*;
;
   logic mclk = 0, nrst = 0, cs1_n = 1, cs2 = 1, cs3_n = 0, qual_n = 0;
   logic we_n = 1, oe_n = 0, h_en = 0, dq_oe_n, p_oe_n, wrdy;
   logic [3:0] bwn = 4'hf, p_in, p_out, hp = 4'h0;
   logic [17:0] ad = 18'h0_0000;
   logic [31:0] dq_in, dq_out, hd = 32'h0;
   int error_cnt = 0, checked = 0;
   always #50 mclk = ~mclk;
   ssc_sram ssc_sram_inst (.mclk(mclk), .nrst(nrst),
      .chip_select_one_n(cs1_n), .chip_select_two(cs2),
      .chip_select_three_n(cs3_n), .clock_qualify_n(qual_n),
      .write_enable_n(we_n), .out_enable_n(oe_n),
      .byte_write_select_n(bwn), .addr(ad), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .parity_io_lines_in(p_in),
      .parity_io_lines_out(p_out), .parity_oe_n(p_oe_n),
      .write_ready(wrdy));
   ssc_host_model ssc_host_model_inst (.mclk(mclk), .h_en(h_en),
      .hd(hd), .hp(hp), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .par_out(p_out), .par_oe_n(p_oe_n), .dq_line(dq_in),
      .par_line(p_in));
   task automatic chk(input logic [35:0] s, input logic [35:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr2(input logic [17:0] a0, input logic [17:0] a1,
                      input logic [31:0] d0, input logic [31:0] d1,
                      input logic [3:0] p0, input logic [3:0] p1);
      @(posedge mclk);
      cs1_n <= 0;
      we_n <= 0;
      ad <= a0;
      bwn <= 4'h0;
      @(posedge mclk);
      ad <= a1;
      @(posedge mclk);
      cs1_n <= 1;
      we_n <= 1;
      bwn <= 4'hf;
      h_en <= 1;
      hd <= d0;
      hp <= p0;
      @(negedge mclk);
      chk(36'({p_oe_n, dq_oe_n}), 36'h3);
      @(posedge mclk);
      hd <= d1;
      hp <= p1;
      // Second data phase follows a write, so only the write masks it
      @(negedge mclk);
      chk(36'({p_oe_n, dq_oe_n}), 36'h3);
      @(posedge mclk);
      h_en <= 0;
   endtask
   task automatic wr(input logic [17:0] a, input logic [3:0] bw,
                     input logic [31:0] d, input logic [3:0] p);
      @(posedge mclk);
      cs1_n <= 0;
      we_n <= 0;
      ad <= a;
      bwn <= bw;
      @(posedge mclk);
      cs1_n <= 1;
      we_n <= 1;
      bwn <= 4'hf;
      @(posedge mclk);
      h_en <= 1;
      hd <= d;
      hp <= p;
      @(negedge mclk);
      chk(36'({p_oe_n, dq_oe_n}), 36'h3);
      @(posedge mclk);
      h_en <= 0;
   endtask
   // Two reads in a row so the checked one never emerges from deselect
   task automatic rd(input logic [17:0] a, input logic c2, input logic oe,
                     input logic st, input logic [35:0] e);
      @(posedge mclk);
      cs1_n <= 0;
      cs2 <= c2;
      oe_n <= oe;
      ad <= a;
      @(posedge mclk);
      @(posedge mclk);
      cs1_n <= 1;
      cs2 <= 1;
      @(negedge mclk);
      chk(36'({p_oe_n, dq_oe_n}), 36'h3);
      @(posedge mclk);
      qual_n <= st;
      repeat (st ? 3 : 1) begin
         @(negedge mclk);
         chk(36'({p_oe_n, dq_oe_n}), {34'h0, {2{oe | !c2}}});
         if (c2)
            chk({p_out, dq_out}, e);
      end
      @(posedge mclk);
      qual_n <= 0;
      oe_n <= 0;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1;
      @(negedge mclk);
      chk(36'({wrdy, p_oe_n, dq_oe_n}), 36'h7);
      wr2(18'h0_0001, 18'h3_ffff, 32'h1234_5678, 32'hdead_beef,
          4'h4, 4'ha);
      wr(18'h0_0001, 4'he, 32'hffff_ffa5, 4'hf);
      // Queued writes need idle edges before the array holds them
      repeat (12) @(posedge mclk);
      rd(18'h0_0001, 1, 0, 0, {4'h5, 32'h1234_56a5});
      rd(18'h3_ffff, 1, 0, 1, {4'ha, 32'hdead_beef});
      rd(18'h3_ffff, 1, 1, 0, {4'ha, 32'hdead_beef});
      rd(18'h0_0001, 0, 0, 0, 36'h0);
      stop_test();
   end
   initial begin
      #(400 * 100);
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
